// File: shared/apc_pkg.sv
// Constants and types shared by the audio port clock and format control.
package apc_pkg;

    // ========================================================
    // Register map and byte transfer
    // ========================================================
    localparam logic [7:0]  SUBADDR_CLK_CTRL = 8'h00;
    localparam logic [2:0]  REG_BYTES        = 3'h4;
    localparam logic [2:0]  LAST_BYTE        = 3'h3;
    localparam logic [31:0] CTRL_RESET       = 32'h01001B22;
    localparam logic [7:0]  UNMAPPED_BYTE    = 8'h00;

    // ========================================================
    // Field positions in the control word
    // ========================================================
    localparam int MCLK_DIV_LSB = 27;
    localparam int FS_DIV_LSB   = 24;
    localparam int SRC_SEL_BIT  = 23;
    localparam int MS_BIT       = 22;
    localparam int XDIV_LSB     = 19;
    localparam int ZDIV_LSB     = 16;
    localparam int IN_WS_LSB    = 11;
    localparam int OUT_WS_LSB   = 8;
    localparam int IN_FMT_LSB   = 4;
    localparam int OUT_FMT_LSB  = 0;

    // ========================================================
    // Divider ratios, word sizes and channel counts
    // ========================================================
    localparam logic [8:0] DIV_1   = 9'h001;
    localparam logic [8:0] DIV_2   = 9'h002;
    localparam logic [8:0] DIV_3   = 9'h003;
    localparam logic [8:0] DIV_4   = 9'h004;
    localparam logic [8:0] DIV_6   = 9'h006;
    localparam logic [8:0] DIV_8   = 9'h008;
    localparam logic [8:0] DIV_16  = 9'h010;
    localparam logic [8:0] DIV_32  = 9'h020;
    localparam logic [8:0] DIV_64  = 9'h040;
    localparam logic [8:0] DIV_96  = 9'h060;
    localparam logic [8:0] DIV_128 = 9'h080;
    localparam logic [8:0] DIV_192 = 9'h0C0;
    localparam logic [8:0] DIV_256 = 9'h100;

    localparam logic [5:0] WS_16 = 6'h10;
    localparam logic [5:0] WS_20 = 6'h14;
    localparam logic [5:0] WS_24 = 6'h18;
    localparam logic [5:0] WS_32 = 6'h20;

    localparam logic [3:0] CH_2 = 4'h2;
    localparam logic [3:0] CH_4 = 4'h4;
    localparam logic [3:0] CH_6 = 4'h6;
    localparam logic [3:0] CH_8 = 4'h8;

    typedef enum logic [1:0]
    {
        JUST_LEFT  = 2'h0,
        JUST_RIGHT = 2'h1,
        JUST_I2S   = 2'h2
    } apc_just_t;

endpackage

// File: hw/apc_tick_div.sv
// Tick divider: passes one of every N source ticks, N taken at wrap.
`timescale 1ns/10ps
module apc_tick_div
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_tick,
    input  wire logic [8:0] i_div,
    output logic            o_tick
);
    import apc_pkg::*;

    typedef struct packed
    {
        logic [8:0] cnt;
        logic [8:0] div;
        logic       tick;
    } apc_div_state_t;

    localparam apc_div_state_t ST_RESET = '{cnt: '0, div: DIV_1, tick: 1'b0};

    apc_div_state_t q;
    apc_div_state_t d;

    // ========================================================
    // Counter
    // ========================================================
    // A new ratio is taken only at the wrap, so a setting change never
    // shortens or stretches the period that is already running.
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        if (i_tick)
        begin
            if (q.cnt + 9'h001 >= q.div)
            begin
                d.cnt  = '0;
                d.div  = i_div;
                d.tick = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + 9'h001;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            q <= ST_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_tick = q.tick;

    // ========================================================
    // Checks
    // ========================================================
    AST_DIV_NO_EARLY_TICK: assert property (@(posedge i_clk_sys)
        disable iff (!i_rstn)
        !i_tick |=> !o_tick)
        else $error("divider ticked without a source tick");

endmodule

// File: hw/apc_clock_ctrl.sv
// Clock and serial audio port control word with its clock dividers.
//
// Summary of operation
// - Control word at subaddress 0x00, four bytes, resets to 01 00 1B 22.
// - Bits 28..27 divide master clock output by 1, 2 or 4.
// - Master clock output divider works in both master and slave roles.
// - Bits 26..24 divide bit clock by 32..512 for frame sync.
// - Frame sync divider used only as master; slave takes frame sync in.
// - Bit 22 selects clock master when set; slave after reset.
// - Bit 23 selects bit clock output source; resets to zero.
// - Bits 21..19 divide master/slave mux by 1,2,3,4,6,8,16,32.
// - As slave with bit 23 clear, first bit clock output follows the slave bit clock input.
// - As master, bits 18..16 divide master clock into the bit clock.
// - As slave, master-to-bit-clock ratio field is ignored.
// - Word size codes 00,01,10,11 mean 32,16,20,24 bits per port.
// - Input and output formats are set independently from bits 7..0.
// - Format codes decode to stereo, TDM left or TDM I2S modes.
`timescale 1ns/10ps
module apc_clock_ctrl
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    input  wire logic              i_txn_start,
    input  wire logic [7:0]        i_sub_addr,
    input  wire logic              i_wr_valid,
    input  wire logic [7:0]        i_wr_byte,
    input  wire logic              i_rd_req,
    output logic      [7:0]        o_rd_byte,
    output logic                   o_rd_valid,
    input  wire logic              i_slave_bit_clock_input,
    input  wire logic              i_frame_sync,
    output logic                   o_frame_sync,
    output logic                   o_frame_sync_oe_n,
    output logic                   o_frame_sync_level,
    output logic                   o_master_clock_out,
    output logic                   o_input_port_bit_clock_out,
    output logic                   o_output_port_bit_clock_out,
    output logic      [5:0]        o_in_word_bits,
    output logic      [5:0]        o_out_word_bits,
    output apc_pkg::apc_just_t     o_in_just,
    output apc_pkg::apc_just_t     o_out_just,
    output logic      [3:0]        o_in_channels,
    output logic      [3:0]        o_out_channels
);
    import apc_pkg::*;

    // ========================================================
    // Decoders
    // ========================================================
    function automatic logic [8:0] rate_div(input logic [2:0] code);
        case (code)
            3'h0:    rate_div = DIV_1;
            3'h1:    rate_div = DIV_2;
            3'h2:    rate_div = DIV_3;
            3'h3:    rate_div = DIV_4;
            3'h4:    rate_div = DIV_6;
            3'h5:    rate_div = DIV_8;
            3'h6:    rate_div = DIV_16;
            default: rate_div = DIV_32;
        endcase
    endfunction

    function automatic logic [5:0] word_bits(input logic [1:0] code);
        case (code)
            2'h0:    word_bits = WS_32;
            2'h1:    word_bits = WS_16;
            2'h2:    word_bits = WS_20;
            default: word_bits = WS_24;
        endcase
    endfunction

    function automatic apc_just_t fmt_just(input logic [3:0] code);
        case (code)
            4'h0, 4'h3, 4'h4, 4'h5: fmt_just = JUST_LEFT;
            4'h1:                   fmt_just = JUST_RIGHT;
            default:                fmt_just = JUST_I2S;
        endcase
    endfunction

    function automatic logic [3:0] fmt_chans(input logic [3:0] code);
        case (code)
            4'h3, 4'h6: fmt_chans = CH_8;
            4'h4, 4'h7: fmt_chans = CH_6;
            4'h5, 4'h8: fmt_chans = CH_4;
            default:    fmt_chans = CH_2;
        endcase
    endfunction

    // Frame sync toggles every half frame, so the ratio is halved here.
    function automatic logic [8:0] fs_half(input logic [2:0] code);
        case (code)
            3'h1:    fs_half = DIV_32;
            3'h2:    fs_half = DIV_64;
            3'h3:    fs_half = DIV_96;
            3'h4:    fs_half = DIV_128;
            3'h5:    fs_half = DIV_192;
            3'h6:    fs_half = DIV_256;
            default: fs_half = DIV_16;
        endcase
    endfunction

    // ========================================================
    // State
    // ========================================================
    typedef struct packed
    {
        logic [31:0] ctrl;
        logic [23:0] stage;
        logic [2:0]  idx;
        logic        mapped;
        logic [7:0]  rd_byte;
        logic        rd_valid;
        logic        sbclk_q;
        logic        in_bclk;
        logic        out_bclk;
        logic        fs_lvl;
        logic        fs_oe_n;
        logic        fs_rx;
        logic [5:0]  in_ws;
        logic [5:0]  out_ws;
        apc_just_t   in_just;
        apc_just_t   out_just;
        logic [3:0]  in_ch;
        logic [3:0]  out_ch;
    } apc_top_state_t;

    localparam apc_top_state_t ST_RESET = '{
        ctrl:     CTRL_RESET,
        fs_oe_n:  1'b1,
        in_ws:    word_bits(CTRL_RESET[IN_WS_LSB +: 2]),
        out_ws:   word_bits(CTRL_RESET[OUT_WS_LSB +: 2]),
        in_just:  fmt_just(CTRL_RESET[IN_FMT_LSB +: 4]),
        out_just: fmt_just(CTRL_RESET[OUT_FMT_LSB +: 4]),
        in_ch:    fmt_chans(CTRL_RESET[IN_FMT_LSB +: 4]),
        out_ch:   fmt_chans(CTRL_RESET[OUT_FMT_LSB +: 4]),
        default:  '0
    };

    apc_top_state_t q;
    apc_top_state_t d;
    logic           z_tick;
    logic           x_tick;
    logic           fs_tick;
    logic           mux_tick;
    logic           is_master;

    assign is_master = q.ctrl[MS_BIT];

    // ========================================================
    // Clock dividers
    // ========================================================
    // master clock out, both roles
    apc_tick_div u_mclk_div
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_tick    (1'b1),
        .i_div     (q.ctrl[MCLK_DIV_LSB + 1] ? DIV_4 :
                    q.ctrl[MCLK_DIV_LSB] ? DIV_2 : DIV_1),
        .o_tick    (o_master_clock_out)
    );

    apc_tick_div u_zdiv
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_tick    (1'b1),
        .i_div     (rate_div(q.ctrl[ZDIV_LSB +: 3])),
        .o_tick    (z_tick)
    );

    assign mux_tick = is_master ? z_tick
                                : (i_slave_bit_clock_input & ~q.sbclk_q);

    apc_tick_div u_xdiv
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_tick    (mux_tick),
        .i_div     (rate_div(q.ctrl[XDIV_LSB +: 3])),
        .o_tick    (x_tick)
    );

    apc_tick_div u_fsdiv
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_tick    (mux_tick),
        .i_div     (fs_half(q.ctrl[FS_DIV_LSB +: 3])),
        .o_tick    (fs_tick)
    );

    // ========================================================
    // Next state
    // ========================================================
    always_comb
    begin
        d = q;
        d.rd_valid = 1'b0;
        d.sbclk_q  = i_slave_bit_clock_input;
        // byte access, most significant byte first
        if (i_txn_start)
        begin
            d.idx    = '0;
            d.mapped = (i_sub_addr == SUBADDR_CLK_CTRL);
        end
        else if (i_wr_valid)
        begin
            if (q.idx < REG_BYTES)
            begin
                d.idx   = q.idx + 3'h1;
                d.stage = {q.stage[15:0], i_wr_byte};
                // all bits stored, unused ones steer nothing
                if (q.mapped && q.idx == LAST_BYTE)
                begin
                    d.ctrl = {q.stage, i_wr_byte};
                end
            end
        end
        else if (i_rd_req)
        begin
            d.rd_valid = 1'b1;
            d.rd_byte  = UNMAPPED_BYTE;
            if (q.idx < REG_BYTES)
            begin
                d.idx = q.idx + 3'h1;
                if (q.mapped)
                begin
                    d.rd_byte = q.ctrl[{2'(LAST_BYTE - q.idx), 3'h0} +: 8];
                end
            end
        end

        d.in_bclk  = q.ctrl[SRC_SEL_BIT] ? x_tick : mux_tick;
        d.out_bclk = q.ctrl[SRC_SEL_BIT] ? mux_tick : x_tick;

        // frame sync driven only as master
        if (is_master && fs_tick)
        begin
            d.fs_lvl = ~q.fs_lvl;
        end
        d.fs_oe_n = ~is_master;
        d.fs_rx   = is_master ? q.fs_lvl : i_frame_sync;

        d.in_ws    = word_bits(q.ctrl[IN_WS_LSB +: 2]);
        d.out_ws   = word_bits(q.ctrl[OUT_WS_LSB +: 2]);
        d.in_just  = fmt_just(q.ctrl[IN_FMT_LSB +: 4]);
        d.out_just = fmt_just(q.ctrl[OUT_FMT_LSB +: 4]);
        d.in_ch    = fmt_chans(q.ctrl[IN_FMT_LSB +: 4]);
        d.out_ch   = fmt_chans(q.ctrl[OUT_FMT_LSB +: 4]);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            q <= ST_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_rd_byte                   = q.rd_byte;
    assign o_rd_valid                  = q.rd_valid;
    assign o_frame_sync                = q.fs_lvl;
    assign o_frame_sync_oe_n           = q.fs_oe_n;
    assign o_frame_sync_level          = q.fs_rx;
    assign o_input_port_bit_clock_out  = q.in_bclk;
    assign o_output_port_bit_clock_out = q.out_bclk;
    assign o_in_word_bits              = q.in_ws;
    assign o_out_word_bits             = q.out_ws;
    assign o_in_just                   = q.in_just;
    assign o_out_just                  = q.out_just;
    assign o_in_channels               = q.in_ch;
    assign o_out_channels              = q.out_ch;

    // ========================================================
    // Checks
    // ========================================================
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    AST_RESET_VALUE: assert property (
        !$past(i_rstn) |-> q.ctrl == CTRL_RESET && o_frame_sync_oe_n)
        else $error("control word not at reset value");
    AST_COMMIT: assert property (
        !i_txn_start && i_wr_valid && q.mapped && q.idx == LAST_BYTE
        |=> q.ctrl == {$past(q.stage), $past(i_wr_byte)})
        else $error("fourth byte did not commit the word");
    AST_MCLK_DIV1: assert property (
        o_master_clock_out && $past(q.ctrl[MCLK_DIV_LSB +: 2]) == 2'h0
        |=> o_master_clock_out)
        else $error("master clock out not undivided");
    AST_MCLK_DIV4: assert property (
        o_master_clock_out && $past(q.ctrl[MCLK_DIV_LSB + 1])
        |=> !o_master_clock_out [*3] ##1 o_master_clock_out)
        else $error("master clock out not divided by four");
    AST_SLAVE_OE: assert property (
        !is_master ##1 !is_master |-> o_frame_sync_oe_n)
        else $error("frame sync driven in slave role");
    AST_MASTER_OE: assert property (
        is_master |=> !o_frame_sync_oe_n
        && o_frame_sync_level == $past(o_frame_sync))
        else $error("frame sync not driven in master role");
    AST_SLAVE_BCLK: assert property (
        !is_master && !q.ctrl[SRC_SEL_BIT] && i_slave_bit_clock_input
        && !q.sbclk_q |=> o_input_port_bit_clock_out)
        else $error("slave bit clock edge not passed on");
    AST_SLAVE_NO_Z: assert property (
        !is_master && !q.ctrl[SRC_SEL_BIT] && !i_slave_bit_clock_input
        |=> !o_input_port_bit_clock_out)
        else $error("bit clock ticked without slave edge");
    AST_WORD16: assert property (
        q.ctrl[IN_WS_LSB +: 2] == 2'h1 |=> o_in_word_bits == WS_16)
        else $error("input word size not decoded");
    AST_FMT_HIGH: assert property (
        q.ctrl[OUT_FMT_LSB + 3] && |q.ctrl[OUT_FMT_LSB +: 3]
        |=> o_out_just == JUST_I2S && o_out_channels == CH_2)
        else $error("high output format codes not two channel I2S");

    COV_MASTER: cover property (is_master ##1 $changed(o_frame_sync));
    COV_WRITE: cover property (i_wr_valid && q.mapped && q.idx == LAST_BYTE);
    COV_READ: cover property (o_rd_valid && o_rd_byte != UNMAPPED_BYTE);
    COV_TDM8: cover property (o_in_channels == CH_8);

endmodule

// File: verif/apc_codec_model.sv
// Converter-side model: slave bit clock and frame sync it drives.
`timescale 1ns/10ps
module apc_codec_model
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_run,
    input  wire logic [3:0] i_period,
    output logic            o_bit_clock,
    output logic            o_frame_sync
);
    logic [3:0] phase_q;
    logic [3:0] ticks_q;

    // ==========================================
    // Bit clock and frame sync
    // ==========================================
    // slave clocks in
    // The bit clock stands low while i_run is low, and the released frame
    // sync line toggles every cycle so a stale level is never trusted.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            phase_q      <= 4'h0;
            ticks_q      <= 4'h0;
            o_bit_clock  <= 1'b0;
            o_frame_sync <= 1'b0;
        end
        else if (!i_run)
        begin
            phase_q      <= 4'h0;
            o_bit_clock  <= 1'b0;
            o_frame_sync <= ~o_frame_sync;
        end
        else
        begin
            phase_q     <= (phase_q >= i_period - 4'h1) ? 4'h0 : phase_q + 4'h1;
            o_bit_clock <= (phase_q == 4'h0);
            if (phase_q == 4'h0)
            begin
                ticks_q <= ticks_q + 4'h1;
                if (ticks_q == 4'hF)
                    o_frame_sync <= ~o_frame_sync;
            end
        end
    end
endmodule

// File: verif/apc_clock_ctrl_tb.sv
// Self-checking bench for the clock and port control word.
`timescale 1ns/10ps
module apc_clock_ctrl_tb;
    import apc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        st = 1'b0;
    logic [7:0]  sa = 8'h00;
    logic        wv = 1'b0;
    logic [7:0]  wb = 8'h00;
    logic        rr = 1'b0;
    logic        run = 1'b0;
    logic [3:0]  per = 4'h2;
    logic [7:0]  rb;
    logic        rv, fs_o, oe_n, lvl, mck, ibk, obk, m_bk, m_fs;
    logic [5:0]  iwb, owb;
    logic [3:0]  ic, oc;
    apc_just_t   ij, oj;
    wire         fs = oe_n ? m_fs : fs_o;
    int          errors = 0;
    int          cmp_count = 0;
    logic [31:0] rs = 32'h0000A035;
    int          divs[8] = '{1, 2, 3, 4, 6, 8, 16, 32};
    int          fsr[8] = '{32, 64, 128, 192, 256, 384, 512, 32};
    int          wsz[4] = '{32, 16, 20, 24};
    int          chn[16] = '{2, 2, 2, 8, 6, 4, 8, 6, 4, 2, 2, 2, 2, 2, 2, 2};
    int          jst[16] = '{0, 1, 2, 0, 0, 0, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2};

    always #50 clk = ~clk;

    apc_clock_ctrl dut
    (
        .i_clk_sys                   (clk),
        .i_rstn                      (rstn),
        .i_txn_start                 (st),
        .i_sub_addr                  (sa),
        .i_wr_valid                  (wv),
        .i_wr_byte                   (wb),
        .i_rd_req                    (rr),
        .o_rd_byte                   (rb),
        .o_rd_valid                  (rv),
        .i_slave_bit_clock_input     (m_bk),
        .i_frame_sync                (fs),
        .o_frame_sync                (fs_o),
        .o_frame_sync_oe_n           (oe_n),
        .o_frame_sync_level          (lvl),
        .o_master_clock_out          (mck),
        .o_input_port_bit_clock_out  (ibk),
        .o_output_port_bit_clock_out (obk),
        .o_in_word_bits              (iwb),
        .o_out_word_bits             (owb),
        .o_in_just                   (ij),
        .o_out_just                  (oj),
        .o_in_channels               (ic),
        .o_out_channels              (oc)
    );

    apc_codec_model codec
    (
        .i_clk_sys    (clk),
        .i_rstn       (rstn),
        .i_run        (run),
        .i_period     (per),
        .o_bit_clock  (m_bk),
        .o_frame_sync (m_fs)
    );

    // ==========================================
    // Helpers
    // ==========================================
    task automatic summarize;
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    function automatic logic [31:0] cw(input logic ms, input logic src,
                                       input int x, input int z,
                                       input int m, input int y);
        logic [31:0] w;
        w = CTRL_RESET;
        w[MS_BIT] = ms;
        w[SRC_SEL_BIT] = src;
        w[XDIV_LSB +: 3] = 3'(x);
        w[ZDIV_LSB +: 3] = 3'(z);
        w[MCLK_DIV_LSB +: 2] = 2'(m);
        w[FS_DIV_LSB +: 3] = 3'(y);
        return w;
    endfunction

    task automatic begin_txn(input logic [7:0] a);
        @(posedge clk);
        st <= 1'b1;
        sa <= a;
        @(posedge clk);
        st <= 1'b0;
    endtask

    // Decoded outputs settle one edge after the last byte is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
        begin_txn(a);
        for (int i = 0; i < n; i++)
        begin
            wb <= d[31 - 8 * i -: 8];
            wv <= 1'b1;
            @(posedge clk);
        end
        wv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input int n, output logic [31:0] d);
        int k;
        d = 32'h00000000;
        begin_txn(a);
        for (int i = 0; i < n; i++)
        begin
            rr <= 1'b1;
            @(posedge clk);
            rr <= 1'b0;
            k = 0;
            @(negedge clk);
            while (rv !== 1'b1 && k < 8)
            begin
                @(negedge clk);
                k++;
            end
            if (k == 8)
            begin
                errors++;
                summarize();
            end
            d = {d[23:0], rb};
            @(posedge clk);
        end
    endtask

    // The last of three tick gaps is measured, so a ratio that is still
    // waiting for its divider to wrap cannot spoil the figure.
    task automatic prd(input int sel, input int ex, input string nm);
        int n = 0;
        int h = 0;
        int t0 = 0;
        int t1 = 0;
        logic pv, cur;
        pv = fs_o;
        while (h < 4)
        begin
            @(negedge clk);
            n++;
            cur = (sel == 0) ? mck : (sel == 1) ? ibk :
                  (sel == 2) ? obk : (fs_o ^ pv);
            pv = fs_o;
            if (cur === 1'b1)
            begin
                h++;
                t0 = t1;
                t1 = n;
            end
            if (n > 5000)
            begin
                errors++;
                summarize();
            end
        end
        chk(nm, t1 - t0, ex);
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial
    begin
        logic [31:0] d, w;
        int p;
        logic v;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("fs_oe_n", oe_n, 1'b1);
        chk("in_bits", iwb, WS_24);
        chk("in_just", ij, JUST_I2S);
        chk("out_ch", oc, CH_2);
        rd(SUBADDR_CLK_CTRL, 4, d);
        chk("reset_word", d, CTRL_RESET);
        rd(SUBADDR_CLK_CTRL, 5, d);
        chk("fifth_byte", d, {CTRL_RESET[23:0], UNMAPPED_BYTE});
        wr(SUBADDR_CLK_CTRL, rnd(), 3);
        rd(SUBADDR_CLK_CTRL, 4, d);
        chk("partial_write", d, CTRL_RESET);
        wr(8'h01, rnd(), 4);
        rd(8'h01, 4, d);
        chk("unmapped", d, 32'h00000000);
        w = rnd();
        wr(SUBADDR_CLK_CTRL, w, 4);
        rd(SUBADDR_CLK_CTRL, 4, d);
        chk("readback", d, w);
        for (int c = 0; c < 16; c++)
        begin
            w = rnd() & 32'hE000E400;
            w = w | CTRL_RESET;
            w[IN_FMT_LSB +: 4] = 4'(c);
            w[OUT_FMT_LSB +: 4] = 4'(15 - c);
            w[IN_WS_LSB +: 2] = 2'(c);
            w[OUT_WS_LSB +: 2] = 2'(c + 1);
            wr(SUBADDR_CLK_CTRL, w, 4);
            @(negedge clk);
            chk("in_just", ij, jst[c]);
            chk("in_ch", ic, chn[c]);
            chk("out_just", oj, jst[15 - c]);
            chk("out_ch", oc, chn[15 - c]);
            chk("in_bits", iwb, wsz[c % 4]);
            chk("out_bits", owb, wsz[(c + 1) % 4]);
        end
        for (int r = 0; r < 2; r++)
            for (int m = 0; m < 4; m++)
            begin
                wr(SUBADDR_CLK_CTRL, cw(r[0], 1'b0, 0, 0, m, 0), 4);
                prd(0, (m == 0) ? 1 : (m == 1) ? 2 : 4, "mclk");
            end
        p = 2 + int'(rnd() % 4);
        @(posedge clk);
        per <= 4'(p);
        run <= 1'b1;
        // port rates differ here once the divider is off 000; the loop also covers 000.
        for (int x = 0; x < 8; x++)
        begin
            wr(SUBADDR_CLK_CTRL, cw(1'b0, 1'b0, x, int'(rnd() % 8), 0, 0), 4);
            prd(1, p, "slave_in_bclk");
            prd(2, p * divs[x], "slave_out_bclk");
            chk("fs_oe_n", oe_n, 1'b1);
        end
        @(negedge clk);
        v = fs;
        @(negedge clk);
        if (fs === v)
            chk("fs_level", lvl, v);
        wr(SUBADDR_CLK_CTRL, cw(1'b0, 1'b1, 1, 0, 0, 0), 4);
        prd(1, p * 2, "src_in_bclk");
        prd(2, p, "src_out_bclk");
        @(posedge clk);
        run <= 1'b0;
        for (int z = 0; z < 8; z++)
        begin
            wr(SUBADDR_CLK_CTRL, cw(1'b1, 1'b0, 0, z, 0, 0), 4);
            prd(1, divs[z], "master_bclk");
            chk("fs_oe_n", oe_n, 1'b0);
        end
        for (int y = 0; y < 8; y++)
        begin
            wr(SUBADDR_CLK_CTRL, cw(1'b1, 1'b0, 0, 0, 0, y), 4);
            prd(3, fsr[y] / 2, "fs_half");
        end
        // A reset in mid-run must bring back the default word and role.
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(SUBADDR_CLK_CTRL, 4, d);
        chk("reset_again", d, CTRL_RESET);
        chk("fs_oe_n", oe_n, 1'b1);
        summarize();
    end
endmodule
